// file: power_mode_pkg.sv
// power_mode_pkg: constants, register map and mode types for the power-mode sequencer.
// assumes one 50 MHz clock and a 32-bit avalon-mm register bus.
// How it works
// - register retention with timers on powers what timers-off powers, plus the slow clock.
// - timers-on register retention wakes on pin, tick and comparator level.
// - tick wake uses short pre-start when start field keeps fast crystal off.
// - tick wake also uses short pre-start when keep-on bit 7 is set.
// - no short pre-start if crystal was not running at entry.
// - register retention wakeup resumes execution, no system reset.
// - standby also powers program memory, data memory, regulator and fast crystal.
// - standby wakes on pin and tick plus radio and misc interrupts.
// - standby ignores the comparator level wake.
// - standby stops cpu clock, keeps io, resumes about 100 ns after wake.
// - active powers all domains, runs the cpu clock and enables the oscillators that the start field selects.
// - code 100 enters register retention, either variant.
// - timers-on variant when slow clock source selects an active source.
// - codes 000 run, 001 deep sleep, 010 and 011 memory retention.
// - slow clock source 111 means none, so timers-off retention.
// - pin, tick, comparator wake flags in bits 7:5, cleared by read or sleep.
// - status bit 3 shows clock from running fast crystal.
package power_mode_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned STANDBY_RESUME_NS = 100;
  localparam int unsigned STANDBY_CYC = STANDBY_RESUME_NS * (CLK_HZ / 1_000_000) / 1_000;
  localparam int unsigned START_US = 100;
  localparam int unsigned START_CYC = START_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SHORT_PRESTART_CYC = 4;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned ADDR_W = 5;
  // byte offsets
  localparam logic [4:0] SLEEP_CMD_OFS = 5'h00;
  localparam logic [4:0] CLK_SETUP_OFS = 5'h04;
  localparam logic [4:0] SLOW_SRC_OFS = 5'h08;
  localparam logic [4:0] IRQ_STATUS_OFS = 5'h0C;
  localparam logic [4:0] IRQ_MASK_OFS = 5'h10;
  localparam logic [4:0] MODE_OFS = 5'h14;
  // sleep command codes
  localparam logic [2:0] CMD_RUN = 3'h0;
  localparam logic [2:0] CMD_DEEP = 3'h1;
  localparam logic [2:0] CMD_MEM_OFF = 3'h2;
  localparam logic [2:0] CMD_MEM_ON = 3'h3;
  localparam logic [2:0] CMD_REG_RET = 3'h4;
  localparam logic [2:0] CMD_STANDBY = 3'h5;
  // fields
  localparam int unsigned WAKE_PIN_BIT = 7;
  localparam int unsigned WAKE_TICK_BIT = 6;
  localparam int unsigned WAKE_COMP_BIT = 5;
  localparam int unsigned KEEP_XTAL_BIT = 7;
  localparam int unsigned OSC_START_HI = 5;
  localparam int unsigned OSC_START_LO = 4;
  localparam logic [1:0] OSC_START_BOTH = 2'h0;
  localparam logic [1:0] OSC_START_RC = 2'h1;
  localparam logic [1:0] OSC_START_XTAL = 2'h2;
  localparam int unsigned XTAL_ACT_BIT = 3;
  localparam int unsigned SLOW_READY_BIT = 6;
  localparam logic [2:0] SLOW_SRC_NONE = 3'h7;
  localparam logic [7:0] CLK_SETUP_RST = 8'h00;
  localparam logic [2:0] SLOW_SRC_RST = 3'h7;
  localparam int unsigned IRQ_WAKE_BIT = 0;
  localparam int unsigned IRQ_SLEEP_BIT = 1;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned SYNC_W = 7;

  typedef enum logic [2:0] {
    MODE_ACTIVE, MODE_DEEP, MODE_MEM_OFF, MODE_MEM_ON, MODE_REG_OFF, MODE_REG_ON, MODE_STANDBY, MODE_WAKING
  } mode_t;
endpackage

// file: input_sync.sv
// input_sync: three-stage synchroniser for asynchronous levels.
// assumes inputs change slowly compared with the clock.
`timescale 1ns/1ps
module input_sync #(
  parameter int unsigned W = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } sync_state_t;

  sync_state_t st, next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = async_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // a bit only changes once the second and third stages agree
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.level[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.level;
endmodule

// file: startup_timer.sv
// startup_timer: down counter that times a wake start-up, pulses done at the end.
// assumes load is a single-cycle pulse; a new load restarts the count.
`timescale 1ns/1ps
module startup_timer (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic load_i,
  input wire logic [power_mode_pkg::CNT_W-1:0] count_i,
  output logic done_o
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [power_mode_pkg::CNT_W-1:0] cnt;
  } timer_state_t;

  timer_state_t st, next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (load_i) begin
      next_st.busy = 1'b1;
      next_st.cnt = count_i;
    end else if (st.busy) begin
      if (st.cnt <= power_mode_pkg::CNT_W'(1)) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt - power_mode_pkg::CNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done_o = st.done;
endmodule

// file: power_mode_sequencer.sv
// power_mode_sequencer: power-down entry, wake selection, start-up timing and power enables.
// assumes wake pins and oscillator status arrive asynchronously; registers over avalon-mm.
`timescale 1ns/1ps
module power_mode_sequencer #(
  parameter int unsigned START_CYC = power_mode_pkg::START_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [power_mode_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic wake_pin_i,
  input wire logic tick_i,
  input wire logic comp_level_i,
  input wire logic radio_irq_i,
  input wire logic misc_irq_a_i,
  input wire logic fast_crystal_running_i,
  input wire logic slow_clock_ready_i,
  output logic cpu_clk_en_o,
  output logic cpu_reset_req_o,
  output logic retention_pwr_o,
  output logic register_pwr_o,
  output logic memory_pwr_o,
  output logic voltage_regulator_en_o,
  output logic slow_clock_en_o,
  output logic fast_crystal_osc_en_o,
  output logic fast_rc_osc_en_o,
  output logic [2:0] mode_o,
  output logic irq_o
);
  typedef struct packed {
    logic wait_n;
    logic [31:0] rdata;
    power_mode_pkg::mode_t mode;
    logic wake_to_reset;
    logic xtal_at_entry;
    logic [7:0] clk_setup;
    logic [2:0] slow_src;
    logic [7:5] wake_flags;
    logic [power_mode_pkg::IRQ_W-1:0] irq_status;
    logic [power_mode_pkg::IRQ_W-1:0] irq_mask;
    logic irq;
    logic reset_req;
    logic cpu_clk_en;
    logic retention_pwr;
    logic register_pwr;
    logic memory_pwr;
    logic voltage_regulator_en;
    logic slow_clk_en;
    logic xtal_en;
    logic rc_en;
  } seq_state_t;

  localparam logic [power_mode_pkg::CNT_W-1:0] LONG_CNT = power_mode_pkg::CNT_W'(START_CYC);
  localparam logic [power_mode_pkg::CNT_W-1:0] SHORT_CNT = power_mode_pkg::CNT_W'(power_mode_pkg::SHORT_PRESTART_CYC);
  localparam logic [power_mode_pkg::CNT_W-1:0] STBY_CNT = power_mode_pkg::CNT_W'(power_mode_pkg::STANDBY_CYC);

  seq_state_t st, next_st;
  logic [power_mode_pkg::SYNC_W-1:0] sync_lv;
  logic pin_w, tick_w, comp_w, radio_w, misc_w, xtal_run, slow_rdy;
  logic tmr_load;
  logic [power_mode_pkg::CNT_W-1:0] tmr_count;
  logic tmr_done;
  logic req, take, wr_take, rd_take;

  input_sync #(.W(power_mode_pkg::SYNC_W)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({slow_clock_ready_i, fast_crystal_running_i, misc_irq_a_i, radio_irq_i, comp_level_i, tick_i, wake_pin_i}),
    .level_o(sync_lv)
  );

  assign {slow_rdy, xtal_run, misc_w, radio_w, comp_w, tick_w, pin_w} = sync_lv;

  startup_timer u_timer (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .load_i(tmr_load),
    .count_i(tmr_count),
    .done_o(tmr_done)
  );

  // register address helper: matches the offset only; wr_take adds byte lane 0, which carries the 8-bit registers
  function automatic logic hit(input logic [power_mode_pkg::ADDR_W-1:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  // short pre-start only when the start field is neither both nor crystal, or the crystal stays on, and it was running at entry
  function automatic logic short_prestart(input logic [7:0] cs, input logic xtal_entry);
    logic [1:0] start;
    start = cs[power_mode_pkg::OSC_START_HI:power_mode_pkg::OSC_START_LO];
    short_prestart = xtal_entry &&
      ((start != power_mode_pkg::OSC_START_BOTH && start != power_mode_pkg::OSC_START_XTAL) ||
       cs[power_mode_pkg::KEEP_XTAL_BIT]);
  endfunction

  assign req = avs_read_i | avs_write_i;
  assign take = req & st.wait_n;
  assign wr_take = take & avs_write_i & avs_byteenable_i[0];
  assign rd_take = take & avs_read_i;

  always_comb begin
    logic [7:0] rd;
    logic wake_any;
    logic [7:5] cause;
    logic xtal_keep;
    rd = 8'h00;
    wake_any = 1'b0;
    cause = 3'h0;
    xtal_keep = st.clk_setup[power_mode_pkg::KEEP_XTAL_BIT];
    next_st = st;
    tmr_load = 1'b0;
    tmr_count = LONG_CNT;
    next_st.reset_req = 1'b0;

    // bus: wait one cycle, then answer at the edge where waitrequest is low
    next_st.wait_n = req & ~st.wait_n;
    if (req && !st.wait_n) begin
      case (avs_address_i)
        power_mode_pkg::SLEEP_CMD_OFS: rd = {st.wake_flags, 5'h00};
        power_mode_pkg::CLK_SETUP_OFS: rd = st.clk_setup;
        power_mode_pkg::SLOW_SRC_OFS: begin
          rd = {1'b0, slow_rdy, 2'h0, xtal_run, st.slow_src};
        end
        power_mode_pkg::IRQ_STATUS_OFS: rd = {6'h00, st.irq_status};
        power_mode_pkg::IRQ_MASK_OFS: rd = {6'h00, st.irq_mask};
        power_mode_pkg::MODE_OFS: rd = {5'h00, st.mode};
        default: rd = 8'h00;
      endcase
      next_st.rdata = {24'h000000, rd};
    end

    if (rd_take && hit(avs_address_i, power_mode_pkg::SLEEP_CMD_OFS)) begin
      next_st.wake_flags = 3'h0;
    end
    if (wr_take && hit(avs_address_i, power_mode_pkg::CLK_SETUP_OFS)) begin
      next_st.clk_setup = avs_writedata_i[7:0];
    end
    if (wr_take && hit(avs_address_i, power_mode_pkg::SLOW_SRC_OFS)) begin
      next_st.slow_src = avs_writedata_i[2:0];
    end
    if (wr_take && hit(avs_address_i, power_mode_pkg::IRQ_MASK_OFS)) begin
      next_st.irq_mask = avs_writedata_i[power_mode_pkg::IRQ_W-1:0];
    end
    if (wr_take && hit(avs_address_i, power_mode_pkg::IRQ_STATUS_OFS)) begin
      next_st.irq_status = st.irq_status & ~avs_writedata_i[power_mode_pkg::IRQ_W-1:0];
    end

    case (st.mode)
      power_mode_pkg::MODE_ACTIVE: begin
        // software is expected to have the fast rc oscillator running before deep sleep
        if (wr_take && hit(avs_address_i, power_mode_pkg::SLEEP_CMD_OFS)) begin
          next_st.xtal_at_entry = xtal_run;
          case (avs_writedata_i[2:0])
            power_mode_pkg::CMD_RUN: next_st.mode = power_mode_pkg::MODE_ACTIVE;
            power_mode_pkg::CMD_DEEP: next_st.mode = power_mode_pkg::MODE_DEEP;
            power_mode_pkg::CMD_MEM_OFF: next_st.mode = power_mode_pkg::MODE_MEM_OFF;
            power_mode_pkg::CMD_MEM_ON: next_st.mode = power_mode_pkg::MODE_MEM_ON;
            power_mode_pkg::CMD_REG_RET: begin
              if (st.slow_src != power_mode_pkg::SLOW_SRC_NONE) begin
                next_st.mode = power_mode_pkg::MODE_REG_ON;
              end else begin
                next_st.mode = power_mode_pkg::MODE_REG_OFF;
              end
            end
            power_mode_pkg::CMD_STANDBY: next_st.mode = power_mode_pkg::MODE_STANDBY;
            default: next_st.mode = power_mode_pkg::MODE_ACTIVE;
          endcase
          if (avs_writedata_i[2:0] != power_mode_pkg::CMD_RUN) begin
            next_st.wake_flags = 3'h0;
            next_st.irq_status[power_mode_pkg::IRQ_SLEEP_BIT] = 1'b1;
          end
        end
      end
      power_mode_pkg::MODE_DEEP, power_mode_pkg::MODE_MEM_OFF, power_mode_pkg::MODE_REG_OFF: begin
        cause[power_mode_pkg::WAKE_PIN_BIT] = pin_w;
        wake_any = pin_w;
        tmr_count = LONG_CNT;
      end
      power_mode_pkg::MODE_MEM_ON, power_mode_pkg::MODE_REG_ON: begin
        cause = {pin_w, tick_w, comp_w};
        wake_any = pin_w | tick_w | comp_w;
        if (st.mode == power_mode_pkg::MODE_REG_ON && tick_w && !pin_w &&
            short_prestart(st.clk_setup, st.xtal_at_entry)) begin
          tmr_count = SHORT_CNT;
        end else begin
          tmr_count = LONG_CNT;
        end
      end
      power_mode_pkg::MODE_STANDBY: begin
        // comparator level is deliberately not a standby wake source
        cause = {pin_w, tick_w, 1'b0};
        wake_any = pin_w | tick_w | radio_w | misc_w;
        tmr_count = STBY_CNT;
      end
      power_mode_pkg::MODE_WAKING: begin
        if (tmr_done) begin
          next_st.mode = power_mode_pkg::MODE_ACTIVE;
          next_st.reset_req = st.wake_to_reset;
        end
      end
      default: next_st.mode = power_mode_pkg::MODE_ACTIVE;
    endcase

    if (wake_any) begin
      tmr_load = 1'b1;
      next_st.mode = power_mode_pkg::MODE_WAKING;
      // only the memory retention and deep modes lose cpu state
      next_st.wake_to_reset = (st.mode == power_mode_pkg::MODE_DEEP) ||
        (st.mode == power_mode_pkg::MODE_MEM_OFF) || (st.mode == power_mode_pkg::MODE_MEM_ON);
      next_st.wake_flags = next_st.wake_flags | cause;
      next_st.irq_status[power_mode_pkg::IRQ_WAKE_BIT] = 1'b1;
    end

    // power enables follow the next mode so each output leaves a flip-flop
    next_st.retention_pwr = (next_st.mode != power_mode_pkg::MODE_DEEP);
    next_st.cpu_clk_en = (next_st.mode == power_mode_pkg::MODE_ACTIVE);
    next_st.slow_clk_en = (next_st.mode != power_mode_pkg::MODE_DEEP) &&
      (next_st.mode != power_mode_pkg::MODE_MEM_OFF) && (next_st.mode != power_mode_pkg::MODE_REG_OFF);
    case (next_st.mode)
      power_mode_pkg::MODE_REG_OFF, power_mode_pkg::MODE_REG_ON: begin
        // both retention variants keep the same domains here; only the slow clock enable, set above, differs
        next_st.register_pwr = 1'b1;
        next_st.memory_pwr = 1'b0;
        next_st.voltage_regulator_en = 1'b0;
        next_st.xtal_en = xtal_keep;
        next_st.rc_en = 1'b0;
      end
      power_mode_pkg::MODE_STANDBY: begin
        next_st.register_pwr = 1'b1;
        next_st.memory_pwr = 1'b1;
        next_st.voltage_regulator_en = 1'b1;
        next_st.xtal_en = 1'b1;
        next_st.rc_en = 1'b0;
      end
      power_mode_pkg::MODE_ACTIVE, power_mode_pkg::MODE_WAKING: begin
        next_st.register_pwr = 1'b1;
        next_st.memory_pwr = 1'b1;
        next_st.voltage_regulator_en = 1'b1;
        next_st.xtal_en = (st.clk_setup[power_mode_pkg::OSC_START_HI:power_mode_pkg::OSC_START_LO] !=
          power_mode_pkg::OSC_START_RC);
        next_st.rc_en = (st.clk_setup[power_mode_pkg::OSC_START_HI:power_mode_pkg::OSC_START_LO] !=
          power_mode_pkg::OSC_START_XTAL);
      end
      default: begin
        next_st.register_pwr = 1'b0;
        next_st.memory_pwr = 1'b0;
        next_st.voltage_regulator_en = 1'b0;
        next_st.xtal_en = 1'b0;
        next_st.rc_en = 1'b0;
      end
    endcase
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
      st.mode <= power_mode_pkg::MODE_ACTIVE;
      st.clk_setup <= power_mode_pkg::CLK_SETUP_RST;
      st.slow_src <= power_mode_pkg::SLOW_SRC_RST;
      st.cpu_clk_en <= 1'b1;
      st.retention_pwr <= 1'b1;
      st.register_pwr <= 1'b1;
      st.memory_pwr <= 1'b1;
      st.voltage_regulator_en <= 1'b1;
      st.slow_clk_en <= 1'b1;
      st.xtal_en <= 1'b1;
      st.rc_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // the cpu clock enable has its own flip-flop so the gate never sees a decode glitch
  assign cpu_clk_en_o = st.cpu_clk_en;
  assign avs_readdata_o = st.rdata;
  assign avs_waitrequest_o = ~st.wait_n;
  assign cpu_reset_req_o = st.reset_req;
  assign retention_pwr_o = st.retention_pwr;
  assign register_pwr_o = st.register_pwr;
  assign memory_pwr_o = st.memory_pwr;
  assign voltage_regulator_en_o = st.voltage_regulator_en;
  assign slow_clock_en_o = st.slow_clk_en;
  assign fast_crystal_osc_en_o = st.xtal_en;
  assign fast_rc_osc_en_o = st.rc_en;
  assign mode_o = st.mode;
  assign irq_o = st.irq;
endmodule

// file: power_mode_sequencer_asserts.sv
// power_mode_sequencer_asserts: port-level checks of the power-mode sequencer.
// assumes binding to power_mode_sequencer; sees only its ports.
`timescale 1ns/1ps
module power_mode_sequencer_asserts #(
  parameter int unsigned START_CYC = 20
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [power_mode_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  input wire logic wake_pin_i,
  input wire logic tick_i,
  input wire logic radio_irq_i,
  input wire logic misc_irq_a_i,
  input wire logic cpu_clk_en_o,
  input wire logic cpu_reset_req_o,
  input wire logic retention_pwr_o,
  input wire logic register_pwr_o,
  input wire logic memory_pwr_o,
  input wire logic voltage_regulator_en_o,
  input wire logic slow_clock_en_o,
  input wire logic fast_crystal_osc_en_o,
  input wire logic fast_rc_osc_en_o,
  input wire logic [2:0] mode_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [2:0] last_sleep;
  logic cmd_take;
  logic quiet;
  // last sleep mode is kept so a late reset pulse can be traced to its cause
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_sleep <= 3'h0;
    end else if (mode_o != 3'h0 && mode_o != 3'h7) begin
      last_sleep <= mode_o;
    end
  end
  assign cmd_take = avs_write_i && !avs_waitrequest_o && avs_address_i == 5'h00 && avs_byteenable_i[0] && mode_o == 3'h0;
  assign quiet = !wake_pin_i && !tick_i && !radio_irq_i && !misc_irq_a_i;
  property p_cpu_clk;
    cpu_clk_en_o == (mode_o == 3'h0);
  endproperty
  a_cpu_clk: assert property (p_cpu_clk) else $error("cpu clock enable does not follow active mode");
  property p_active_pwr;
    mode_o == 3'h0 |-> retention_pwr_o && register_pwr_o && memory_pwr_o && voltage_regulator_en_o
      && slow_clock_en_o && (fast_crystal_osc_en_o || fast_rc_osc_en_o);
  endproperty
  a_active_pwr: assert property (p_active_pwr) else $error("active mode lacks a power enable");
  property p_standby_pwr;
    mode_o == 3'h6 |-> retention_pwr_o && register_pwr_o && memory_pwr_o && voltage_regulator_en_o
      && fast_crystal_osc_en_o;
  endproperty
  a_standby_pwr: assert property (p_standby_pwr) else $error("standby lacks a power enable");
  property p_reg_pwr;
    mode_o inside {3'h4, 3'h5} |-> retention_pwr_o && register_pwr_o;
  endproperty
  a_reg_pwr: assert property (p_reg_pwr) else $error("register retention lost register power");
  property p_no_reset;
    cpu_reset_req_o |-> last_sleep inside {3'h1, 3'h2, 3'h3};
  endproperty
  a_no_reset: assert property (p_no_reset) else $error("reset request after retention or standby");
  property p_reg_entry;
    cmd_take && avs_writedata_i[2:0] == 3'h4 |=> mode_o inside {3'h4, 3'h5};
  endproperty
  a_reg_entry: assert property (p_reg_entry) else $error("code 4 did not enter register retention");
  property p_run_code;
    cmd_take && avs_writedata_i[2:0] == 3'h0 |=> mode_o == 3'h0;
  endproperty
  a_run_code: assert property (p_run_code) else $error("code 0 left active mode");
  property p_deep_code;
    cmd_take && avs_writedata_i[2:0] == 3'h1 |=> mode_o == 3'h1;
  endproperty
  a_deep_code: assert property (p_deep_code) else $error("code 1 did not enter deep sleep");
  property p_standby_quiet;
    (mode_o == 3'h6 && quiet) [*6] |=> mode_o == 3'h6;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet) else $error("standby left with no wake source");
  property p_standby_resume;
    mode_o == 3'h7 && $past(mode_o) == 3'h6 |-> ##[1:6] mode_o == 3'h0;
  endproperty
  a_standby_resume: assert property (p_standby_resume) else $error("standby resume too slow");
  property p_wait_ans;
    $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("bus answer not after one wait cycle");
  property p_wait_one;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low for more than one cycle");
  c_reset_pulse: cover property (cpu_reset_req_o);
  c_standby_wake: cover property (mode_o == 3'h7 && $past(mode_o) == 3'h6);
  c_reg_on: cover property (mode_o == 3'h5);
endmodule

bind power_mode_sequencer power_mode_sequencer_asserts #(.START_CYC(START_CYC)) chk_u (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_waitrequest_o(avs_waitrequest_o), .wake_pin_i(wake_pin_i), .tick_i(tick_i),
  .radio_irq_i(radio_irq_i), .misc_irq_a_i(misc_irq_a_i), .cpu_clk_en_o(cpu_clk_en_o),
  .cpu_reset_req_o(cpu_reset_req_o), .retention_pwr_o(retention_pwr_o), .register_pwr_o(register_pwr_o),
  .memory_pwr_o(memory_pwr_o), .voltage_regulator_en_o(voltage_regulator_en_o),
  .slow_clock_en_o(slow_clock_en_o), .fast_crystal_osc_en_o(fast_crystal_osc_en_o),
  .fast_rc_osc_en_o(fast_rc_osc_en_o), .mode_o(mode_o));

// file: power_mode_sequencer_test.sv
// power_mode_sequencer_test: directed bench for sleep entry, wake and registers.
// assumes the checker is bound separately; start-up shortened to 20 cycles.
`timescale 1ns/1ps
module power_mode_sequencer_test;
  localparam int SIM_START = 20;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [4:0] addr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hF;
  logic [4:0] wake = 5'h00; // pin, tick, comparator, radio, misc
  logic xtal = 1'b0;
  logic [31:0] rdata;
  logic wreq, clk_en, rst_req, mem_pwr, voltage_regulator, xosc_en, irq;
  logic [2:0] mode;
  int err_count = 0;
  int cmp_count = 0;
  int pulses = 0;
  int n;
  power_mode_sequencer #(.START_CYC(SIM_START)) dut_u (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .wake_pin_i(wake[0]), .tick_i(wake[1]), .comp_level_i(wake[2]), .radio_irq_i(wake[3]),
    .misc_irq_a_i(wake[4]), .fast_crystal_running_i(xtal), .slow_clock_ready_i(1'b1),
    .cpu_clk_en_o(clk_en), .cpu_reset_req_o(rst_req), .retention_pwr_o(), .register_pwr_o(),
    .memory_pwr_o(mem_pwr), .voltage_regulator_en_o(voltage_regulator), .slow_clock_en_o(),
    .fast_crystal_osc_en_o(xosc_en), .fast_rc_osc_en_o(), .mode_o(mode), .irq_o(irq));
  always #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    if (rst_req === 1'b1) begin
      pulses++;
    end
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
    int k = 0;
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= {24'h0, d};
    wr <= w;
    rd <= !w;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    chk("bus answer", 1'b0, wreq);
    if (wreq !== 1'b0) tally_and_finish();
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wr8(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(what, exp, q);
  endtask
  task automatic wait_mode(input logic [2:0] m, input int lim, output int c);
    c = 0;
    while (mode !== m && c < lim) begin
      @(negedge ref_clk_i);
      c++;
    end
    chk("mode", m, mode);
    if (mode !== m) tally_and_finish();
  endtask
  task automatic enter(input logic [2:0] cmd, input logic [2:0] m);
    int c;
    wr8(5'h00, {5'h00, cmd});
    wait_mode(m, 4, c);
    chk("cpu clock in sleep", 1'b0, clk_en);
  endtask
  // the source is held until the wake completes, then dropped long enough for the synchroniser to clear
  task automatic wake_src(input int i, output int c);
    int k;
    @(posedge ref_clk_i);
    wake[i] <= 1'b1;
    wait_mode(3'h7, 10, k);
    wait_mode(3'h0, 200, c);
    chk("cpu clock after wake", 1'b1, clk_en);
    @(posedge ref_clk_i);
    wake[i] <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
  endtask
  task automatic ignored(input int i, input logic [2:0] m);
    @(posedge ref_clk_i);
    wake[i] <= 1'b1;
    repeat (10) @(negedge ref_clk_i);
    chk("ignored source", m, mode);
    @(posedge ref_clk_i);
    wake[i] <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
  endtask
  task automatic s_reset();
    chk("reset mode", 3'h0, mode);
    rd_chk("setup reset", 5'h04, 32'h0);
    rd_chk("slow source reset", 5'h08, 32'h47);
    rd_chk("unmapped", 5'h18, 32'h0);
    @(posedge ref_clk_i);
    be <= 4'h0;
    wr8(5'h04, 8'h30);
    @(posedge ref_clk_i);
    be <= 4'hF;
    rd_chk("lane off write", 5'h04, 32'h0);
    wr8(5'h04, 8'h30);
    rd_chk("setup write", 5'h04, 32'h30);
    wr8(5'h04, 8'h00);
  endtask
  task automatic s_codes();
    int p;
    wr8(5'h00, 8'h00);
    repeat (3) @(negedge ref_clk_i);
    chk("run code", 3'h0, mode);
    for (int c = 1; c < 4; c++) begin
      p = pulses;
      enter(c[2:0], c[2:0]);
      wake_src(0, n);
      chk("reset pulse", p + 1, pulses);
    end
  endtask
  task automatic s_reg_off();
    int p;
    wr8(5'h08, 8'h07);
    enter(3'h4, 3'h4);
    ignored(2, 3'h4);
    p = pulses;
    wake_src(0, n);
    chk("long start", 1'b1, n >= SIM_START);
    chk("no reset", p, pulses);
    rd_chk("pin flag", 5'h00, 32'h80);
    rd_chk("flag cleared", 5'h00, 32'h0);
  endtask
  task automatic s_reg_on();
    wr8(5'h08, 8'h01);
    enter(3'h4, 3'h5);
    wake_src(2, n);
    rd_chk("comparator flag", 5'h00, 32'h20);
    enter(3'h4, 3'h5);
    wake_src(1, n);
    chk("tick long start", 1'b1, n >= SIM_START);
    rd_chk("tick flag", 5'h00, 32'h40);
  endtask
  task automatic s_tick(input logic [7:0] setup, input logic x, input logic short_exp);
    @(posedge ref_clk_i);
    xtal <= x;
    wr8(5'h04, setup);
    rd_chk("crystal status", 5'h08, {28'h4, x, 3'h1});
    enter(3'h4, 3'h5);
    wake_src(1, n);
    chk("short start", short_exp, n < SIM_START / 2);
  endtask
  task automatic s_standby();
    enter(3'h5, 3'h6);
    chk("standby power", 3'h7, {mem_pwr, voltage_regulator, xosc_en});
    ignored(2, 3'h6);
    wake_src(3, n);
    chk("standby resume", 1'b1, n <= 6);
    enter(3'h5, 3'h6);
    wake_src(4, n);
  endtask
  task automatic s_irq();
    wr8(5'h0C, 8'h03);
    wr8(5'h10, 8'h01);
    chk("irq idle", 1'b0, irq);
    enter(3'h5, 3'h6);
    wake_src(3, n);
    chk("irq raised", 1'b1, irq);
    rd_chk("irq status", 5'h0C, 32'h3);
    wr8(5'h0C, 8'h01);
    repeat (2) @(negedge ref_clk_i);
    chk("irq cleared", 1'b0, irq);
    wr8(5'h10, 8'h02);
    repeat (2) @(negedge ref_clk_i);
    chk("irq sleep bit", 1'b1, irq);
    wr8(5'h0C, 8'h02);
    repeat (2) @(negedge ref_clk_i);
    chk("irq all clear", 1'b0, irq);
    rd_chk("irq status clear", 5'h0C, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    s_reset();
    s_codes();
    s_reg_off();
    s_reg_on();
    s_tick(8'h10, 1'b1, 1'b1);
    s_tick(8'h80, 1'b1, 1'b1);
    s_tick(8'h80, 1'b0, 1'b0);
    s_standby();
    s_irq();
    tally_and_finish();
  end
endmodule
